//--- dlfb_params.svh
// Offsets, field positions, reset values and timing counts of the diagnostic flag bank.
`ifndef DLFB_PARAMS_SVH
`define DLFB_PARAMS_SVH
`define DLFB_SEL_OFS         8'h80
`define DLFB_REF_LOSS_OFS    8'h84
`define DLFB_RSVD_FLAG_OFS   8'h85
`define DLFB_HOST_GATE_OFS   8'h86
`define DLFB_MEDIA_GATE_OFS  8'h87
`define DLFB_HOST_GEN_OFS    8'h88
`define DLFB_MEDIA_GEN_OFS   8'h89
`define DLFB_HOST_UNLK_OFS   8'h8A
`define DLFB_MEDIA_UNLK_OFS  8'h8B
`define DLFB_DATA_BASE       8'hC0
`define DLFB_REF_LOSS_BIT    7
`define DLFB_FLAG_RESET      8'h00
`define DLFB_SEL_RESET       8'h00
`define DLFB_SEL_RT_LAST     8'h06
`define DLFB_SEL_GATED_FIRST 8'h11
`define DLFB_SEL_GATED_LAST  8'h15
`define DLFB_TOTAL_LSB_NIB   4'h8
`define DLFB_CLK_PERIOD_NS   100
`define DLFB_GUARD_TIME_NS   10000
`define DLFB_GUARD_CYCLES    (`DLFB_GUARD_TIME_NS / `DLFB_CLK_PERIOD_NS)
`endif

//--- dlfb_pkg.sv
// Types shared by the diagnostic flag bank files.
package dlfb_pkg;
   typedef logic [7:0] dlfb_byte_t;
   typedef logic [5:0] dlfb_win_idx_t;
   typedef logic [3:0] dlfb_lane_t;
endpackage

//--- dlfb_window_mem.sv
// Small memory holding the diagnostics data window, with registered read data.
`timescale 1ns/1ns
module dlfb_window_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 64,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic             rd_en,
   input  wire logic [AW-1:0]    rd_addr,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rd_data <= '0;
      else if (rd_en)
         rd_data <= mem[rd_addr];
   end
endmodule

//--- dlfb_diag_latched_flag_bank.sv
// Latched clear-on-read diagnostic flags, content selector and diagnostics data window.
//
// Contract
// [R1] Loss of reference clock latches bit 7 at 0x84; clear on read; rest reserved.
// [R2] Host lane gating complete latches in 0x86, bit n-1 for lane n.
// [R3] Media lane gating complete latches in 0x87, bit n-1 for lane n.
// [R4] Host lane generator failure latches in 0x88, clear on read.
// [R5] Media lane generator failure latches in 0x89, clear on read.
// [R6] Host lane checker loss of lock latches in 0x8A, clear on read.
// [R7] Media lane checker loss of lock latches in 0x8B; 0x8C-0x95 reserved.
// [R8] Each flag has a mask; masked flags do not raise the alert.
// [R9] Selector at 0x80 chooses what the window at 0xC0-0xFF shows.
// [R10] Unsupported selector value reverts to zero; window then reads zeroes.
// [R11] Total bits counter LSB carries a latched checker sync loss indicator.
// [R12] Window refreshes within the guard time after a selector write, unsignalled.
// [R13] A read clears only bits it returned; events during the read stay latched.
`timescale 1ns/1ns
`include "dlfb_params.svh"
module dlfb_diag_latched_flag_bank (
   input  wire logic                     ref_clk,
   input  wire logic                     reset_n,
   input  wire logic [7:0]               reg_addr,
   input  wire logic                     reg_wr_en,
   input  wire logic [7:0]               reg_wr_data,
   input  wire logic                     reg_rd_en,
   output logic      [7:0]               reg_rd_data,
   input  wire logic                     ref_clock_loss_flag,
   input  wire logic [7:0]               host_gating_done_flag,
   input  wire logic [7:0]               media_gating_done_flag,
   input  wire logic [7:0]               host_gen_fail_flag,
   input  wire logic [7:0]               media_gen_fail_flag,
   input  wire logic [7:0]               host_checker_unlock_flag,
   input  wire logic [7:0]               media_checker_unlock_flag,
   input  wire logic                     ref_clock_loss_mask,
   input  wire logic [7:0]               host_gating_done_mask,
   input  wire logic [7:0]               media_gating_done_mask,
   input  wire logic [7:0]               host_gen_fail_mask,
   input  wire logic [7:0]               media_gen_fail_mask,
   input  wire logic [7:0]               host_checker_unlock_mask,
   input  wire logic [7:0]               media_checker_unlock_mask,
   output logic                          diag_flag_alert,
   input  wire logic [15:0]              counter_restart,
   output dlfb_pkg::dlfb_byte_t          diag_content_select,
   output dlfb_pkg::dlfb_win_idx_t       diag_data_index,
   input  wire dlfb_pkg::dlfb_byte_t     diag_data_byte
);
   localparam int GUARD_CYC = `DLFB_GUARD_CYCLES;
   localparam logic [7:0] FLAG_OFS [6] = '{`DLFB_HOST_GATE_OFS, `DLFB_MEDIA_GATE_OFS,
      `DLFB_HOST_GEN_OFS, `DLFB_MEDIA_GEN_OFS, `DLFB_HOST_UNLK_OFS, `DLFB_MEDIA_UNLK_OFS};

   logic                     ref_loss_reg;
   logic                     ref_hit;
   logic [7:0]               lane_ev [6];
   logic [7:0]               flag_reg [6];
   logic [5:0]               flag_hit;
   dlfb_pkg::dlfb_byte_t     sel_reg;
   logic                     sel_wr;
   dlfb_pkg::dlfb_win_idx_t  idx_reg;
   logic                     pass_done_reg;
   logic [15:0]              sync_loss_reg;
   logic                     counter_sel;
   dlfb_pkg::dlfb_lane_t     lane;
   dlfb_pkg::dlfb_byte_t     win_wdata;
   logic                     win_rd;
   logic                     from_win_reg;
   dlfb_pkg::dlfb_byte_t     rd_byte_reg;
   dlfb_pkg::dlfb_byte_t     rd_byte_next;
   dlfb_pkg::dlfb_byte_t     win_q;

   function automatic logic sel_supported(input dlfb_pkg::dlfb_byte_t v);
      return (v <= `DLFB_SEL_RT_LAST) ||
             (v >= `DLFB_SEL_GATED_FIRST && v <= `DLFB_SEL_GATED_LAST);
   endfunction

   // ****************************************************************
   // Latched flags
   // ****************************************************************
   assign lane_ev[0] = host_gating_done_flag; // [R2]
   assign lane_ev[1] = media_gating_done_flag; // [R3]
   assign lane_ev[2] = host_gen_fail_flag; // [R4]
   assign lane_ev[3] = media_gen_fail_flag; // [R5]
   assign lane_ev[4] = host_checker_unlock_flag; // [R6]
   assign lane_ev[5] = media_checker_unlock_flag; // [R7]
   assign ref_hit    = reg_rd_en && reg_addr == `DLFB_REF_LOSS_OFS;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         ref_loss_reg <= 1'b0;
      else
         ref_loss_reg <= ref_clock_loss_flag | (ref_loss_reg & ~ref_hit); // [R1] [R13]
   end

   // A read clears the byte it returned; an event in the same cycle sets again.
   for (genvar k = 0; k < 6; k++)
   begin : g_flag
      assign flag_hit[k] = reg_rd_en && reg_addr == FLAG_OFS[k];
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
         if (!reset_n)
            flag_reg[k] <= `DLFB_FLAG_RESET;
         else
            flag_reg[k] <= lane_ev[k] | (flag_hit[k] ? 8'h00 : flag_reg[k]); // [R2] [R13]
      end
   end

   assign diag_flag_alert = (ref_loss_reg & ~ref_clock_loss_mask) |                  // [R8]
      (|(flag_reg[0] & ~host_gating_done_mask))     | (|(flag_reg[1] & ~media_gating_done_mask)) |
      (|(flag_reg[2] & ~host_gen_fail_mask))        | (|(flag_reg[3] & ~media_gen_fail_mask)) |
      (|(flag_reg[4] & ~host_checker_unlock_mask))  |
      (|(flag_reg[5] & ~media_checker_unlock_mask));

   // ****************************************************************
   // Content selector and window refresh
   // ****************************************************************
   assign sel_wr = reg_wr_en && reg_addr == `DLFB_SEL_OFS;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         sel_reg <= `DLFB_SEL_RESET;
      else if (sel_wr)
         sel_reg <= sel_supported(reg_wr_data) ? reg_wr_data : `DLFB_SEL_RESET; // [R10]
   end

   // The sweep runs all the time so the window tracks the data source; a
   // selector write restarts it, so a full pass ends 64 cycles later.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         idx_reg <= 6'h00;
      else if (sel_wr)
         idx_reg <= 6'h00; // [R12]
      else
         idx_reg <= idx_reg + 6'h01;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         pass_done_reg <= 1'b0;
      else if (sel_wr)
         pass_done_reg <= 1'b0;
      else if (idx_reg == 6'h3F)
         pass_done_reg <= 1'b1;
   end

   // Host lanes occupy indices 0-7 and media lanes 8-15.
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         sync_loss_reg <= 16'h0000;
      else
         sync_loss_reg <= {media_checker_unlock_flag, host_checker_unlock_flag} | // [R11]
                          (sync_loss_reg & ~counter_restart);
   end

   assign counter_sel = sel_reg[7:5] == 3'h0 && !sel_reg[3] &&
                        sel_reg[2:0] >= 3'h2 && sel_reg[2:0] <= 3'h5;
   assign lane        = {2'(sel_reg[1:0] - 2'h2), idx_reg[5:4]};

   always_comb
   begin
      if (sel_reg == `DLFB_SEL_RESET)
         win_wdata = 8'h00; // [R10]
      else if (counter_sel && idx_reg[3:0] == `DLFB_TOTAL_LSB_NIB)
         win_wdata = {diag_data_byte[7:1], sync_loss_reg[lane]}; // [R11]
      else
         win_wdata = diag_data_byte; // [R9]
   end

   assign diag_content_select = sel_reg;
   assign diag_data_index     = idx_reg;

   // ****************************************************************
   // Register read
   // ****************************************************************
   assign win_rd = reg_rd_en && reg_addr >= `DLFB_DATA_BASE;

   dlfb_window_mem #(
      .WIDTH (8),
      .DEPTH (64)
   ) u_window (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .wr_en   (1'b1),
      .wr_addr (idx_reg),
      .wr_data (win_wdata),
      .rd_en   (win_rd),
      .rd_addr (reg_addr[5:0]),
      .rd_data (win_q)
   );

   always_comb
   begin
      rd_byte_next = 8'h00;
      if (reg_addr == `DLFB_SEL_OFS)
         rd_byte_next = sel_reg;
      if (ref_hit)
         rd_byte_next = {ref_loss_reg, 7'h00}; // [R1]
      for (int k = 0; k < 6; k++)
         if (reg_addr == FLAG_OFS[k])
            rd_byte_next = flag_reg[k];
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_byte_reg  <= 8'h00;
         from_win_reg <= 1'b0;
      end
      else if (reg_rd_en)
      begin
         rd_byte_reg  <= rd_byte_next;
         from_win_reg <= win_rd;
      end
   end

   assign reg_rd_data = from_win_reg ? win_q : rd_byte_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   property p_latch(int k);
      (lane_ev[k] != 8'h00 ##1 !flag_hit[k] ##1 flag_hit[k]) |=>
         (reg_rd_data & $past(lane_ev[k], 3)) == $past(lane_ev[k], 3);
   endproperty

   chk_ref_loss_read: assert property ((ref_clock_loss_flag ##1 !ref_hit ##1 ref_hit) |=> // [R1]
      reg_rd_data == 8'h80) else $error("reference clock loss not reported");
   chk_host_gate: assert property (p_latch(0)) else $error("host gating flag lost"); // [R2]
   chk_media_gate: assert property (p_latch(1)) else $error("media gating flag lost"); // [R3]
   chk_host_gen: assert property (p_latch(2)) else $error("host generator flag lost"); // [R4]
   chk_media_gen: assert property (p_latch(3)) else $error("media generator flag lost"); // [R5]
   chk_host_unlock: assert property (p_latch(4)) else $error("host unlock flag lost"); // [R6]
   chk_media_unlock: assert property (p_latch(5)) else $error("media unlock flag lost"); // [R7]
   chk_alert_unmasked: assert property ((ref_clock_loss_flag && !ref_clock_loss_mask) |=> // [R8]
      diag_flag_alert) else $error("unmasked flag gave no alert");
   chk_sel_revert: assert property ((sel_wr && !sel_supported(reg_wr_data)) |=> // [R10]
      sel_reg == 8'h00 ##[1:GUARD_CYC] win_wdata == 8'h00) else $error("bad selector kept");
   chk_refresh_bound: assert property (sel_wr |=> !pass_done_reg ##[1:GUARD_CYC] // [R12]
      pass_done_reg) else $error("window not refreshed in guard time");
   chk_sync_loss_hold: assert property ((host_checker_unlock_flag[0] ##1 // [R11]
      !counter_restart[0]) |=> sync_loss_reg[0]) else $error("sync loss not held");
   chk_read_clears: assert property ((flag_hit[4] && lane_ev[4] == 8'h00) |=> // [R13]
      flag_reg[4] == 8'h00 && reg_rd_data == $past(flag_reg[4])) else $error("read clear wrong");

   cov_sel_valid: cover property (sel_wr && reg_wr_data == 8'h12 ##65 pass_done_reg);
   cov_read_set: cover property (flag_hit[0] && flag_reg[0] != 8'h00);
   cov_alert: cover property ($rose(diag_flag_alert));
endmodule

//--- dlfb_host_model.sv
// Host controller model that drives the byte-wide management register port.
`timescale 1ns/1ns
`include "dlfb_params.svh"
module dlfb_host_model (
   input  wire logic       ref_clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr_en,
   output logic      [7:0] reg_wr_data,
   output logic            reg_rd_en,
   input  wire logic [7:0] reg_rd_data
);
   // ****************************************
   // Register access tasks
   // ****************************************
   initial
   begin
      reg_addr    = 8'h00;
      reg_wr_en   = 1'b0;
      reg_wr_data = 8'h00;
      reg_rd_en   = 1'b0;
   end
   // Released address and data lines show the inverse of the last value.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr    = a;
      reg_wr_data = d;
      reg_wr_en   = 1'b1;
      @(negedge ref_clk);
      reg_wr_en   = 1'b0;
      reg_addr    = ~a;
      reg_wr_data = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr  = a;
      reg_rd_en = 1'b1;
      @(negedge ref_clk);
      reg_rd_en = 1'b0;
      reg_addr  = ~a;
      d         = reg_rd_data;
   endtask
   // No completion signal exists, so the host waits out the guard time.
   task automatic guard_wait();
      repeat (`DLFB_GUARD_CYCLES) @(negedge ref_clk);
   endtask
endmodule

//--- testbench.sv
// Self-checking testbench of the diagnostic flag bank.
`timescale 1ns/1ns
`include "dlfb_params.svh"
module testbench;
   // ****************************************
   // Signals, helpers and checks
   // ****************************************
   logic                    ref_clk, reset_n, reg_wr_en, reg_rd_en, ev_ref, diag_flag_alert;
   logic [7:0]              reg_addr, reg_wr_data, reg_rd_data, rd_val, v, e, w;
   logic [7:0]              ev [6];
   logic [7:0]              mk [7];
   logic [15:0]             counter_restart;
   logic [5:0]              x;
   logic [31:0]             seed = 32'h116D;
   int                      n_fail, check_count;
   dlfb_pkg::dlfb_byte_t    diag_content_select, diag_data_byte;
   dlfb_pkg::dlfb_win_idx_t diag_data_index;
   logic [7:0]              sel_in [5]  = '{8'h07, 8'h16, 8'hC0, 8'h05, 8'h15};
   logic [7:0]              sel_out [5] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h15};
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic [7:0] src(logic [7:0] s, logic [5:0] i);
      return {i, 2'b10} ^ s;
   endfunction
   function automatic logic [7:0] fl_addr(int i);
      return (i == 0) ? 8'h84 : 8'h85 + 8'(i);
   endfunction
   assign diag_data_byte = src(diag_content_select, diag_data_index);
   task automatic cmp_byte(string what, logic [7:0] ex, logic [7:0] s);
      check_count++;
      if (s !== ex)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, ex, s);
      end
   endtask
   task automatic chk_rd(logic [7:0] a, logic [7:0] ex);
      host_u.rd(a, rd_val);
      cmp_byte($sformatf("byte %h", a), ex, rd_val);
   endtask
   task automatic set_ev(int i, logic [7:0] val);
      if (i == 0)
         ev_ref = val[7];
      else
         ev[i-1] = val;
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   dlfb_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));
   dlfb_diag_latched_flag_bank dut_u (.ref_clk(ref_clk), .reset_n(reset_n),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
      .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .ref_clock_loss_flag(ev_ref),
      .host_gating_done_flag(ev[0]), .media_gating_done_flag(ev[1]),
      .host_gen_fail_flag(ev[2]), .media_gen_fail_flag(ev[3]),
      .host_checker_unlock_flag(ev[4]), .media_checker_unlock_flag(ev[5]),
      .ref_clock_loss_mask(mk[0][7]), .host_gating_done_mask(mk[1]),
      .media_gating_done_mask(mk[2]), .host_gen_fail_mask(mk[3]),
      .media_gen_fail_mask(mk[4]), .host_checker_unlock_mask(mk[5]),
      .media_checker_unlock_mask(mk[6]), .diag_flag_alert(diag_flag_alert),
      .counter_restart(counter_restart), .diag_content_select(diag_content_select),
      .diag_data_index(diag_data_index), .diag_data_byte(diag_data_byte));
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      stop_test();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      reset_n = 1'b0;
      ev_ref = 1'b0;
      counter_restart = 16'h0000;
      foreach (ev[j]) ev[j] = 8'h00;
      foreach (mk[j]) mk[j] = 8'h00;
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      for (int a = 8'h80; a < 8'h8C; a++) chk_rd(8'(a), 8'h00);
      for (int i = 0; i < 7; i++)
      begin
         v = rnd();
         if (i == 0) v[7] = 1'b1;
         if (i == 5) v[0] = 1'b1;
         e = (i == 0) ? (v & 8'h80) : v;
         foreach (mk[j]) mk[j] = 8'hFF;
         mk[i] = rnd();
         set_ev(i, v);
         @(negedge ref_clk);
         set_ev(i, 8'h00);
         cmp_byte("alert", {7'h00, |(e & ~mk[i])}, {7'h00, diag_flag_alert});
         chk_rd(fl_addr(i), e);
         chk_rd(fl_addr(i), 8'h00);
      end
      foreach (mk[j]) mk[j] = 8'h00;
      ev[2] = 8'h3C;
      ev_ref = 1'b1;
      chk_rd(8'h88, 8'h3C);
      ev[2] = 8'h00;
      ev_ref = 1'b0;
      chk_rd(8'h88, 8'h3C);
      chk_rd(8'h88, 8'h00);
      chk_rd(8'h84, 8'h80);
      cmp_byte("alert", 8'h00, {7'h00, diag_flag_alert});
      host_u.wr(8'h84, 8'hFF);
      chk_rd(8'h84, 8'h00);
      chk_rd(8'h85, 8'h00);
      chk_rd(8'h8C, 8'h00);
      for (int k = 0; k < 5; k++)
      begin
         host_u.wr(8'h80, sel_in[k]);
         chk_rd(8'h80, sel_out[k]);
         host_u.guard_wait();
      end
      host_u.wr(8'h80, 8'h12);
      host_u.guard_wait();
      w = src(8'h12, 6'd8);
      chk_rd(8'hC8, {w[7:1], 1'b1});
      for (int k = 0; k < 4; k++)
      begin
         v = rnd();
         x = {v[5:4], 1'b0, v[2:0]};
         chk_rd(8'hC0 | {2'b00, x}, src(8'h12, x));
      end
      @(negedge ref_clk);
      counter_restart = 16'h0001;
      @(negedge ref_clk);
      counter_restart = 16'h0000;
      host_u.guard_wait();
      chk_rd(8'hC8, {w[7:1], 1'b0});
      host_u.wr(8'h80, 8'h00);
      host_u.guard_wait();
      chk_rd(8'hC5, 8'h00);
      stop_test();
   end
endmodule
